/* File: mode_regs_map.svh */
/*
 * Offsets, field positions, reset values, refresh-rate codes and constants of the mode-register bank.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
// Summary of operation
// [RULE_01] Controller keeps clock within code's band
// [RULE_02] Read latency column chosen by read inversion
// [RULE_03] Write latency from set A or B
// [RULE_04] Count write recovery cycles before precharge
// [RULE_05] Count read-to-precharge cycles before precharge
// [RULE_06] Burst length 32 adds eight clocks
// [RULE_07] Postamble half or one-and-half clock
// [RULE_08] Bits 6 and 7 enable inversion
// [RULE_09] Write updates only selected set-point copy
// [RULE_10] Active set-point copy drives behaviour
// [RULE_11] Controller matches pull-up point on channels
// [RULE_12] Repair lock sticky until power-on reset
// [RULE_13] Lock refuses writing one to repair entry
// [RULE_14] Refresh rate field reports eight codes
// [RULE_15] Controller scales refresh by reported multiplier
// [RULE_16] Derating needed reports code 110
// [RULE_17] Refresh register stores only bits 6:3
// [RULE_18] Repair entry one enters, zero exits
// [RULE_19] Thermal offset codes 00, 01, 10
// [RULE_20] Flag set on rate change, read clears
// [RULE_21] Flag zero at power-up
// [RULE_22] Maker identity read-only, writes ignored
// [RULE_23] Write leveling holds device in write state
`ifndef MODE_REGS_MAP_SVH
`define MODE_REGS_MAP_SVH

`define MA_LATENCY        6'h02
`define MA_IO_CONFIG      6'h03
`define MA_REFRESH_THERM  6'h04
`define MA_MAKER_ID       6'h05
`define MA_SETPOINT       6'h0d

`define LAT_RL_LSB        0
`define LAT_WL_LSB        3
`define LAT_WLS_BIT       6
`define LAT_WRLEV_BIT     7
`define IO_PUCAL_BIT      0
`define IO_WRPST_BIT      1
`define IO_LOCK_BIT       2
`define IO_PULLDOWN_STRENGTH_LSB       3
`define IO_RDINV_BIT      6
`define IO_WRINV_BIT      7
`define RT_RATE_LSB       0
`define RT_ABORT_BIT      3
`define RT_ENTRY_BIT      4
`define RT_OFFS_LSB       5
`define RT_TUF_BIT        7
`define SP_WR_BIT         6
`define SP_OP_BIT         7

`define LAT_RESET         8'h00
`define IO_RESET          8'h31
`define RATE_RESET        3'h3
`define RATE_DERATE       3'h6
`define BL32_EXTRA        8'h08
`define MAKER_ID_VALUE    8'h5a

`endif

/* File: mode_regs_pkg.sv */
/*
 * Types of the mode-register bank.
 * Assumes the map header supplies the numbers.
 */
package mode_regs_pkg;
    typedef enum logic [1:0]
    {
        CNT_IDLE  = 2'b00,
        CNT_RUN   = 2'b01,
        CNT_FIRE  = 2'b10
    } pre_state_t;
endpackage : mode_regs_pkg

/* File: setpoint_if.sv */
/*
 * Carrier between the register bank and the latency decoder.
 * Assumes both ends share clk_i.
 */
`timescale 1ns/1ps
interface setpoint_if;
    logic [7:0] lat_op;
    logic [7:0] io_op;
    logic [7:0] rl;
    logic [7:0] wl;
    logic [7:0] write_recovery_cycles;
    logic [7:0] read_to_precharge_cycles;
    modport bank (output lat_op, output io_op, input rl, input wl, input write_recovery_cycles, input read_to_precharge_cycles);
    modport dec  (input lat_op, input io_op, output rl, output wl, output write_recovery_cycles, output read_to_precharge_cycles);
endinterface : setpoint_if

/* File: latency_decode.sv */
/*
 * Latency lookup: read and write latency, write recovery and read-to-precharge.
 * Assumes the operand bytes are the active set-point copies.
 */
`timescale 1ns/1ps
`include "mode_regs_map.svh"
module latency_decode
(
    setpoint_if.dec sp
);
    localparam logic [7:0] RL_PLAIN [8] = '{8'h06, 8'h0a, 8'h0e, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
    localparam logic [7:0] RL_INV   [8] = '{8'h06, 8'h0c, 8'h10, 8'h16, 8'h1c, 8'h20, 8'h24, 8'h28};
    localparam logic [7:0] WL_A     [8] = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12};
    localparam logic [7:0] WL_B     [8] = '{8'h04, 8'h08, 8'h0c, 8'h12, 8'h16, 8'h1a, 8'h1e, 8'h22};
    localparam logic [7:0] WRITE_RECOVERY_CYCLES      [8] = '{8'h06, 8'h0a, 8'h10, 8'h14, 8'h18, 8'h1e, 8'h22, 8'h28};
    localparam logic [7:0] READ_TO_PRECHARGE_CYCLES     [8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10};

    wire [2:0] rl_code = sp.lat_op[`LAT_RL_LSB +: 3];
    wire [2:0] wl_code = sp.lat_op[`LAT_WL_LSB +: 3];

    assign sp.rl   = sp.io_op[`IO_RDINV_BIT] ? RL_INV[rl_code] : RL_PLAIN[rl_code]; // [RULE_02]
    assign sp.wl   = sp.lat_op[`LAT_WLS_BIT] ? WL_B[wl_code] : WL_A[wl_code];       // [RULE_03]
    assign sp.write_recovery_cycles  = WRITE_RECOVERY_CYCLES[wl_code];
    assign sp.read_to_precharge_cycles = READ_TO_PRECHARGE_CYCLES[rl_code];
endmodule : latency_decode

/* File: dram_mode_regs.sv */
/*
 * Mode-register bank: latency, I/O configuration, refresh/thermal and maker identity,
 * with two set-point copies, auto-precharge delay counter and write leveling hold.
 * Assumes commands are decoded to one-cycle strobes synchronous to clk_i.
 */
`timescale 1ns/1ps
`include "mode_regs_map.svh"
module dram_mode_regs
#(
    parameter int CNT_W = 8
)
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       mrw_i,
    input  wire logic       mrr_i,
    input  wire logic [5:0] ma_i,
    input  wire logic [7:0] op_i,
    input  wire logic       rate_upd_i,
    input  wire logic [2:0] rate_i,
    input  wire logic       derate_i,
    input  wire logic       wr_ap_i,
    input  wire logic       rd_ap_i,
    input  wire logic       bl32_i,
    output logic [7:0]      mrr_data_o,
    output logic            mrr_valid_o,
    output logic            precharge_o,
    output logic [7:0]      read_latency_o,
    output logic [7:0]      write_latency_o,
    output logic            write_postamble_sel_o,
    output logic            read_inversion_en_o,
    output logic            write_inversion_en_o,
    output logic            pullup_cal_point_o,
    output logic [2:0]      pulldown_strength_o,
    output logic            repair_lock_o,
    output logic            repair_entry_o,
    output logic            sr_abort_o,
    output logic [1:0]      thermal_offset_o,
    output logic            wr_leveling_o,
    output logic            cmd_block_o
);
    // Counter must hold the longest recovery count plus the burst-32 extension
    if (CNT_W < 7)
    begin : g_cnt_w_check
        $error("CNT_W too small for recovery counts");
    end

    setpoint_if sp ();

    logic [7:0]       lat_q [2];
    logic [7:0]       io_q  [2];
    logic             sp_wr_q;
    logic             sp_op_q;
    logic             lock_q;
    logic [3:0]       rt_w_q;
    logic [2:0]       rate_q;
    logic             tuf_q;
    logic [CNT_W-1:0] cnt_q;
    mode_regs_pkg::pre_state_t st_q;

    // Write leveling hold lets only latency-register writes through
    wire wrlev    = lat_q[sp_op_q][`LAT_WRLEV_BIT];
    wire mrw_ok   = mrw_i && (!wrlev || ma_i == `MA_LATENCY);                     // [RULE_23]
    wire mrr_ok   = mrr_i && !wrlev;
    wire wr_lat   = mrw_ok && ma_i == `MA_LATENCY;
    wire wr_io    = mrw_ok && ma_i == `MA_IO_CONFIG;
    wire wr_rt    = mrw_ok && ma_i == `MA_REFRESH_THERM;
    wire wr_sp    = mrw_ok && ma_i == `MA_SETPOINT;
    wire rd_rt    = mrr_ok && ma_i == `MA_REFRESH_THERM;
    wire [7:0] io_wr_val = {op_i[7:3], op_i[`IO_LOCK_BIT] | lock_q, op_i[1:0]};
    wire       entry_d   = op_i[`RT_ENTRY_BIT] & ~lock_q;                         // [RULE_13]
    wire [2:0] rate_in   = derate_i ? `RATE_DERATE : rate_i;                      // [RULE_16]
    wire       rate_chg  = rate_upd_i && rate_in != rate_q;
    wire [7:0] rt_view   = {tuf_q, rt_w_q, rate_q};
    wire [7:0] io_act    = io_q[sp_op_q];                                          // [RULE_10]
    wire [CNT_W-1:0] wr_cnt = CNT_W'(sp.write_recovery_cycles);                                      // [RULE_04]
    wire [CNT_W-1:0] rd_cnt = CNT_W'(sp.read_to_precharge_cycles) + (bl32_i ? CNT_W'(`BL32_EXTRA) : '0); // [RULE_05] [RULE_06]

    assign sp.lat_op = lat_q[sp_op_q];
    assign sp.io_op  = io_act;

    latency_decode u_dec
    (
        .sp (sp)
    );

    // Two set-point copies, write lands on the selected one
    for (genvar g = 0; g < 2; g++) begin : g_copy
        always_ff @(posedge clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
            begin
                lat_q[g] <= `LAT_RESET;
                io_q[g]  <= `IO_RESET;
            end
            else
            begin
                if (wr_lat && sp_wr_q == 1'(g)) lat_q[g] <= op_i;               // [RULE_09]
                if (wr_io && sp_wr_q == 1'(g)) io_q[g] <= io_wr_val;             // [RULE_09]
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sp_wr_q <= 1'b0;
            sp_op_q <= 1'b0;
        end
        else if (wr_sp)
        begin
            sp_wr_q <= op_i[`SP_WR_BIT];
            sp_op_q <= op_i[`SP_OP_BIT];
        end
    end

    // Lock is sticky on either copy; only reset clears it
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            lock_q <= 1'b0;
        else if (wr_io && op_i[`IO_LOCK_BIT])
            lock_q <= 1'b1;                                                        // [RULE_12]
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rt_w_q <= 4'h0;
        else if (wr_rt)
            rt_w_q <= {op_i[6:5], entry_d, op_i[`RT_ABORT_BIT]};                  // [RULE_17] [RULE_18] [RULE_19]
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rate_q <= `RATE_RESET;
        else if (rate_upd_i)
            rate_q <= rate_in;                                                     // [RULE_14]
    end

    // Change wins over a read-clear in the same cycle
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            tuf_q <= 1'b0;                                                         // [RULE_21]
        else if (rate_chg)
            tuf_q <= 1'b1;                                                         // [RULE_20]
        else if (rd_rt)
            tuf_q <= 1'b0;                                                         // [RULE_20]
    end

    // Auto-precharge delay counter
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q  <= mode_regs_pkg::CNT_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            unique case (st_q)
                mode_regs_pkg::CNT_IDLE:
                begin
                    if (wr_ap_i)
                    begin
                        cnt_q <= wr_cnt - CNT_W'(1);                              // [RULE_04]
                        st_q  <= mode_regs_pkg::CNT_RUN;
                    end
                    else if (rd_ap_i)
                    begin
                        cnt_q <= rd_cnt - CNT_W'(1);                              // [RULE_05]
                        st_q  <= mode_regs_pkg::CNT_RUN;
                    end
                end
                mode_regs_pkg::CNT_RUN:
                begin
                    if (cnt_q == CNT_W'(1))
                        st_q <= mode_regs_pkg::CNT_FIRE;
                    else
                        cnt_q <= cnt_q - CNT_W'(1);
                end
                mode_regs_pkg::CNT_FIRE:
                    st_q <= mode_regs_pkg::CNT_IDLE;
                default:
                    st_q <= mode_regs_pkg::CNT_IDLE;
            endcase
        end
    end

    wire [7:0] rd_mux = (ma_i == `MA_REFRESH_THERM) ? rt_view :
                        (ma_i == `MA_MAKER_ID)      ? `MAKER_ID_VALUE : 8'h00;   // [RULE_22]

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mrr_data_o  <= 8'h00;
            mrr_valid_o <= 1'b0;
        end
        else
        begin
            mrr_valid_o <= mrr_ok;
            if (mrr_ok) mrr_data_o <= rd_mux;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            precharge_o           <= 1'b0;
            read_latency_o        <= 8'h06;
            write_latency_o       <= 8'h04;
            write_postamble_sel_o <= 1'b0;
            read_inversion_en_o   <= 1'b0;
            write_inversion_en_o  <= 1'b0;
            pullup_cal_point_o    <= 1'b1;
            pulldown_strength_o   <= 3'h6;
            repair_lock_o         <= 1'b0;
            repair_entry_o        <= 1'b0;
            sr_abort_o            <= 1'b0;
            thermal_offset_o      <= 2'h0;
            wr_leveling_o         <= 1'b0;
            cmd_block_o           <= 1'b0;
        end
        else
        begin
            precharge_o           <= st_q == mode_regs_pkg::CNT_FIRE;
            read_latency_o        <= sp.rl;
            write_latency_o       <= sp.wl;
            write_postamble_sel_o <= io_act[`IO_WRPST_BIT];                      // [RULE_07]
            read_inversion_en_o   <= io_act[`IO_RDINV_BIT];                      // [RULE_08]
            write_inversion_en_o  <= io_act[`IO_WRINV_BIT];                      // [RULE_08]
            pullup_cal_point_o    <= io_act[`IO_PUCAL_BIT];
            pulldown_strength_o   <= io_act[`IO_PULLDOWN_STRENGTH_LSB +: 3];
            repair_lock_o         <= lock_q;
            repair_entry_o        <= rt_w_q[1];
            sr_abort_o            <= rt_w_q[0];
            thermal_offset_o      <= rt_w_q[3:2];
            wr_leveling_o         <= wrlev;
            cmd_block_o           <= wrlev;                                        // [RULE_23]
        end
    end

    // Counter starts: precharge output rises one edge after the FIRE state
    sequence wr_start_s;
        st_q == mode_regs_pkg::CNT_IDLE && wr_ap_i && sp.write_recovery_cycles == 8'h06;
    endsequence

    sequence rd16_start_s;
        st_q == mode_regs_pkg::CNT_IDLE && !wr_ap_i && rd_ap_i && !bl32_i && sp.read_to_precharge_cycles == 8'h08;
    endsequence

    sequence rd32_start_s;
        st_q == mode_regs_pkg::CNT_IDLE && !wr_ap_i && rd_ap_i && bl32_i && sp.read_to_precharge_cycles == 8'h08;
    endsequence

    lock_sticky_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_12]
        lock_q |=> lock_q)
        else $error("repair lock dropped");

    entry_refused_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_13]
        (wr_rt && lock_q) |=> !rt_w_q[1])
        else $error("repair entry accepted under lock");

    entry_exit_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_18]
        (wr_rt && !op_i[`RT_ENTRY_BIT]) |=> !rt_w_q[1])
        else $error("repair entry not cleared");

    tuf_set_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_20]
        rate_chg |=> tuf_q)
        else $error("update flag not set on change");

    tuf_clear_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_20]
        (rd_rt && !rate_chg) |=> !tuf_q)
        else $error("update flag not cleared by read");

    tuf_hold_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_20]
        (!tuf_q && !rate_chg) |=> !tuf_q)
        else $error("update flag set without change");

    derate_code_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_16]
        (rate_upd_i && derate_i) |=> rate_q == 3'h6)
        else $error("derate code wrong");

    rate_code_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_14]
        (rate_upd_i && !derate_i) |=> rate_q == $past(rate_i))
        else $error("refresh rate code not stored");

    wr_recovery_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_04]
        wr_start_s |-> ##1 !precharge_o [*6] ##1 precharge_o)
        else $error("write recovery count wrong");

    rd_recovery_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_05]
        rd16_start_s |-> ##1 !precharge_o [*8] ##1 precharge_o)
        else $error("read precharge count wrong");

    rd_bl32_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_06]
        rd32_start_s |-> ##1 !precharge_o [*8] ##9 precharge_o)
        else $error("burst 32 read precharge wrong");

    precharge_pulse_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_04]
        precharge_o |=> !precharge_o)
        else $error("precharge pulse too long");

    stored_bits_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_17]
        (wr_rt && !lock_q) |=> rt_w_q == $past(op_i[6:3]))
        else $error("refresh write bits wrong");

    inv_select_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_02]
        (io_act[`IO_RDINV_BIT] && sp.lat_op[2:0] == 3'h7) |=> read_latency_o == 8'h28)
        else $error("inverted read latency wrong");

    wl_select_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_03]
        (sp.lat_op[`LAT_WLS_BIT] && sp.lat_op[5:3] == 3'h7) |=> write_latency_o == 8'h22)
        else $error("set B write latency wrong");

    copy0_write_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_09]
        (wr_io && !sp_wr_q) |=> $stable(io_q[1]))
        else $error("inactive copy written");

    copy1_write_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_09]
        (wr_io && sp_wr_q) |=> $stable(io_q[0]))
        else $error("inactive copy written");

    active_copy0_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_10]
        (!sp_op_q && !io_q[0][`IO_WRINV_BIT]) |=> !write_inversion_en_o)
        else $error("output not from active copy");

    active_copy1_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_10]
        (sp_op_q && io_q[1][`IO_WRINV_BIT]) |=> write_inversion_en_o)
        else $error("output not from active copy");

    postamble_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_07]
        io_act[`IO_WRPST_BIT] |=> write_postamble_sel_o)
        else $error("postamble select not applied");

    maker_read_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_22]
        (mrr_ok && ma_i == `MA_MAKER_ID) |=> mrr_valid_o && mrr_data_o == `MAKER_ID_VALUE)
        else $error("identity read wrong");

    wrlev_block_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_23]
        (wrlev && mrw_i && ma_i == `MA_IO_CONFIG) |=> $stable(io_q[0]) && $stable(io_q[1]))
        else $error("write accepted during leveling");

    wrlev_cmd_a : assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_23]
        wrlev |=> cmd_block_o)
        else $error("command block not raised");
endmodule : dram_mode_regs

/* File: mode_ctrl_model.sv */
/*
 * Controller model that issues mode register writes and reads to the bank.
 * Assumes the bank samples commands on the rising edge of clk_i.
 */
`timescale 1ns/1ps
module mode_ctrl_model
(
    input  wire logic       clk_i,
    input  wire logic       mrr_valid_i,
    input  wire logic [7:0] mrr_data_i,
    output logic            mrw_o,
    output logic            mrr_o,
    output logic [5:0]      ma_o,
    output logic [7:0]      op_o
);
    // Clock stays at 125 MHz, inside the band of the lowest latency code
    // Single channel here, so one pull-up point setting serves every channel
    // Refresh scaling by the reported rate is left to the scheduler above
    initial
    begin
        mrw_o = 1'b0;
        mrr_o = 1'b0;
        ma_o  = 6'h00;
        op_o  = 8'h00;
    end

    task automatic mrw(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        mrw_o = 1'b1;
        ma_o  = a;
        op_o  = d;
        @(posedge clk_i);
        #1;
        mrw_o = 1'b0;
        ma_o  = ~a;
        op_o  = ~d;
    endtask : mrw

    task automatic mrr(input logic [5:0] a, output logic v, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        mrr_o = 1'b1;
        ma_o  = a;
        @(posedge clk_i);
        #1;
        mrr_o = 1'b0;
        ma_o  = ~a;
        v     = mrr_valid_i;
        d     = mrr_data_i;
    endtask : mrr
endmodule : mode_ctrl_model

/* File: dram_mode_regs_latency_refresh_tb.sv */
/*
 * Self-checking bench of the mode-register bank.
 * Assumes the controller model drives the mode-register command inputs; the bench drives auto-precharge and rate inputs.
 */
`timescale 1ns/1ps
`include "mode_regs_map.svh"
module dram_mode_regs_latency_refresh_tb;
    logic       clk_i = 1'b0, resetn_i = 1'b0, mrw_i, mrr_i, rate_upd_i = 1'b0, derate_i = 1'b0;
    logic       wr_ap_i = 1'b0, rd_ap_i = 1'b0, bl32_i = 1'b0, mrr_valid_o, precharge_o;
    logic       write_postamble_sel_o, read_inversion_en_o, write_inversion_en_o, pullup_cal_point_o;
    logic       repair_lock_o, repair_entry_o, sr_abort_o, wr_leveling_o, cmd_block_o;
    logic [5:0] ma_i;
    logic [7:0] op_i, mrr_data_o, read_latency_o, write_latency_o;
    logic [2:0] rate_i = 3'h0, pulldown_strength_o, prev;
    logic [1:0] thermal_offset_o;
    int         error_cnt = 0, tests_run = 0, cyc = 0;
    localparam logic [7:0] RL_A[8] = '{8'h06, 8'h0a, 8'h0e, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
    localparam logic [7:0] RL_B[8] = '{8'h06, 8'h0c, 8'h10, 8'h16, 8'h1c, 8'h20, 8'h24, 8'h28};
    localparam logic [7:0] WL_A[8] = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12};
    localparam logic [7:0] WL_B[8] = '{8'h04, 8'h08, 8'h0c, 8'h12, 8'h16, 8'h1a, 8'h1e, 8'h22};
    localparam logic [7:0] WRITE_RECOVERY_CYCLES[8]  = '{8'h06, 8'h0a, 8'h10, 8'h14, 8'h18, 8'h1e, 8'h22, 8'h28};
    localparam logic [7:0] READ_TO_PRECHARGE_CYCLES[8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10};
    // I/O and refresh outputs packed in register bit order; leveling outputs in bits 1:0
    wire  [7:0] io_w = {write_inversion_en_o, read_inversion_en_o, pulldown_strength_o, repair_lock_o,
                        write_postamble_sel_o, pullup_cal_point_o};
    wire  [7:0] rt_w = {1'b0, thermal_offset_o, repair_entry_o, sr_abort_o, 3'h0};
    wire  [7:0] lv_w = {6'h00, cmd_block_o, wr_leveling_o};

    always #4 clk_i = ~clk_i;

    dram_mode_regs #(.CNT_W(8)) i_dut
    (
        .clk_i(clk_i), .resetn_i(resetn_i), .mrw_i(mrw_i), .mrr_i(mrr_i), .ma_i(ma_i), .op_i(op_i),
        .rate_upd_i(rate_upd_i), .rate_i(rate_i), .derate_i(derate_i), .wr_ap_i(wr_ap_i),
        .rd_ap_i(rd_ap_i), .bl32_i(bl32_i), .mrr_data_o(mrr_data_o), .mrr_valid_o(mrr_valid_o),
        .precharge_o(precharge_o), .read_latency_o(read_latency_o), .write_latency_o(write_latency_o),
        .write_postamble_sel_o(write_postamble_sel_o), .read_inversion_en_o(read_inversion_en_o),
        .write_inversion_en_o(write_inversion_en_o), .pullup_cal_point_o(pullup_cal_point_o),
        .pulldown_strength_o(pulldown_strength_o), .repair_lock_o(repair_lock_o),
        .repair_entry_o(repair_entry_o), .sr_abort_o(sr_abort_o), .thermal_offset_o(thermal_offset_o),
        .wr_leveling_o(wr_leveling_o), .cmd_block_o(cmd_block_o)
    );

    mode_ctrl_model i_ctrl
    (
        .clk_i(clk_i), .mrr_valid_i(mrr_valid_o), .mrr_data_i(mrr_data_o),
        .mrw_o(mrw_i), .mrr_o(mrr_i), .ma_o(ma_i), .op_o(op_i)
    );

    task automatic end_sim;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Write, then wait until the stored value reaches the outputs
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        i_ctrl.mrw(a, d);
        @(posedge clk_i);
        #1;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic ev, input logic [7:0] exp);
        logic       v;
        logic [7:0] d;
        i_ctrl.mrr(a, v, d);
        chk({7'h00, v}, {7'h00, ev});
        if (ev)
            chk(d, exp);
    endtask : rd

    // Auto-precharge request; counts cycles up to the internal precharge
    task automatic ap(input logic w, input logic b, input logic [7:0] n);
        logic [7:0] k;
        @(posedge clk_i);
        @(posedge clk_i);
        #1;
        wr_ap_i = w;
        rd_ap_i = ~w;
        bl32_i  = b;
        @(posedge clk_i);
        #1;
        wr_ap_i = 1'b0;
        rd_ap_i = 1'b0;
        k       = 8'h00;
        while (precharge_o !== 1'b1 && k < 8'h40)
        begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk(k, n);
    endtask : ap

    task automatic rate_set(input logic [2:0] r, input logic dr);
        @(posedge clk_i);
        #1;
        rate_upd_i = 1'b1;
        rate_i     = r;
        derate_i   = dr;
        @(posedge clk_i);
        #1;
        rate_upd_i = 1'b0;
        rate_i     = ~r;
        derate_i   = 1'b0;
    endtask : rate_set

    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        chk(io_w, 8'h31);
        chk(rt_w, 8'h00);
        chk(lv_w, 8'h00);
        rd(`MA_REFRESH_THERM, 1'b1, 8'h03);
        for (int p = 0; p < 2; p++)
        begin
            wr(`MA_IO_CONFIG, p[0] ? 8'h71 : 8'h31);
            for (int c = 0; c < 8; c++)
            begin
                wr(`MA_LATENCY, {1'b0, p[0], c[2:0], c[2:0]});
                chk(read_latency_o, p[0] ? RL_B[c] : RL_A[c]);
                chk(write_latency_o, p[0] ? WL_B[c] : WL_A[c]);
                ap(1'b1, p[0], WRITE_RECOVERY_CYCLES[c]);
                ap(1'b0, p[0], READ_TO_PRECHARGE_CYCLES[c] + (p[0] ? 8'h08 : 8'h00));
            end
        end
        wr(`MA_IO_CONFIG, 8'h31);
        wr(`MA_SETPOINT, 8'h40);
        wr(`MA_IO_CONFIG, 8'hc2);
        chk(io_w, 8'h31);
        wr(`MA_SETPOINT, 8'hc0);
        chk(io_w, 8'hc2);
        wr(`MA_SETPOINT, 8'h00);
        chk(io_w, 8'h31);
        wr(`MA_REFRESH_THERM, 8'h10);
        chk(rt_w, 8'h10);
        wr(`MA_REFRESH_THERM, 8'h00);
        chk(rt_w, 8'h00);
        wr(`MA_IO_CONFIG, 8'h35);
        wr(`MA_IO_CONFIG, 8'h31);
        chk(io_w, 8'h35);
        wr(`MA_REFRESH_THERM, 8'hdf);
        chk(rt_w, 8'h48);
        rd(`MA_REFRESH_THERM, 1'b1, 8'h4b);
        wr(`MA_REFRESH_THERM, 8'h20);
        chk(rt_w, 8'h20);
        prev = 3'h3;
        for (int r = 0; r < 8; r++)
        begin
            rate_set(r[2:0], 1'b0);
            rd(`MA_REFRESH_THERM, 1'b1, {r[2:0] != prev, 4'h4, r[2:0]});
            rd(`MA_REFRESH_THERM, 1'b1, {1'b0, 4'h4, r[2:0]});
            prev = r[2:0];
        end
        rate_set(3'h7, 1'b0);
        rd(`MA_REFRESH_THERM, 1'b1, {1'b0, 4'h4, 3'h7});
        rate_set(3'h1, 1'b1);
        rd(`MA_REFRESH_THERM, 1'b1, {1'b1, 4'h4, `RATE_DERATE});
        wr(`MA_LATENCY, 8'h80);
        chk(lv_w, 8'h03);
        rd(`MA_REFRESH_THERM, 1'b0, 8'h00);
        wr(`MA_IO_CONFIG, 8'hf1);
        chk(io_w, 8'h35);
        wr(`MA_LATENCY, 8'h00);
        chk(lv_w, 8'h00);
        wr(`MA_MAKER_ID, 8'h00);
        rd(`MA_MAKER_ID, 1'b1, `MAKER_ID_VALUE);
        rd(6'h3f, 1'b1, 8'h00);
        resetn_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        chk(io_w, 8'h31);
        rd(`MA_REFRESH_THERM, 1'b1, 8'h03);
        end_sim();
    end
endmodule : dram_mode_regs_latency_refresh_tb
